// >>> include/aep_defines.vh
/*
 Holds the register addresses, field positions and reset values
 for the analog-enable and pump-current register pair.
 Assumes it is included by its bare name from the core design files.
*/
`ifndef AEP_DEFINES_VH
`define AEP_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses and width
// ----------------------------------------------------------------
`define AEP_ADDR_W            5
`define AEP_DATA_W            24
`define AEP_ADDR_ANALOG       5'h08
`define AEP_ADDR_PUMP         5'h09

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AEP_RST_ANALOG        24'hc1beff
`define AEP_RST_PUMP          24'h403264

// ----------------------------------------------------------------
// Analog-enable fields
// ----------------------------------------------------------------
`define AEP_BIT_BIAS          0
`define AEP_BIT_PUMP_ON       1
`define AEP_BIT_PD_ON         2
`define AEP_BIT_REFBUF        3
`define AEP_BIT_OSCBUF        4
`define AEP_BIT_PAD_EN        5
`define AEP_BIT_DIVCLK        7
`define AEP_BIT_PRESCLK       9
`define AEP_BIT_PRESBIAS      10
`define AEP_BIT_AMP           11
`define AEP_BIT_HIREF         21

// ----------------------------------------------------------------
// Pump-current fields
// ----------------------------------------------------------------
`define AEP_DN_LSB            0
`define AEP_DN_MSB            6
`define AEP_UP_LSB            7
`define AEP_UP_MSB            13
`define AEP_OFS_LSB           14
`define AEP_OFS_MSB           20
`define AEP_BIT_OFS_UP        21
`define AEP_BIT_OFS_DN        22
`define AEP_BIT_HICP          23

`endif

// >>> core/aep_reg24.v
/*
 One 24-bit read-write configuration register with a reset value.
 Assumes a write strobe on the core clock from the serial decoder.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aep_defines.vh"

module aep_reg24 #(
    parameter [23:0] RST_VAL = 24'h000000
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        sys_rst,
    // Write side
    input  wire        wr_en,
    input  wire [23:0] wr_data,
    // Stored value
    output reg  [23:0] value
);

    // ----------------------------------------------------------------
    // Storage, every bit kept as written
    // ----------------------------------------------------------------
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            value <= RST_VAL;
        end else if (wr_en) begin
            value <= wr_data;
        end
    end

endmodule // aep_reg24
`default_nettype wire

// >>> core/aep_pad_ctrl.v
/*
 Output-enable control for the shared lock/serial-out pin.
 Assumes synchronised inputs on the core clock; enable is active low.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aep_defines.vh"

module aep_pad_ctrl (
    // Clock and reset
    input  wire core_clk,
    input  wire sys_rst,
    // Controls
    input  wire pad_en,
    input  wire output_select_bit,
    input  wire foreign_addr,
    // Pin enable, low while driving
    output reg  pin_oe_n
);

    // ----------------------------------------------------------------
    // Drive decision
    // ----------------------------------------------------------------
    reg next_oe_n;

    always @* begin
        if (!pad_en) begin
            next_oe_n = 1'b1;
        end else if (output_select_bit) begin
            next_oe_n = 1'b0;
        end else begin
            next_oe_n = foreign_addr;
        end
    end

    // Released while reset is held; the pad bit resets to 1, so the pin can drive before setup
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_oe_n <= 1'b1;
        end else begin
            pin_oe_n <= next_oe_n;
        end
    end

endmodule // aep_pad_ctrl
`default_nettype wire

// >>> core/aep_regs.v
/*
 Analog-enable and pump-current register pair with pin control.
 Assumes a serial decoder on core_clk that presents address, data and
 a one-cycle write strobe, plus a read address; the output-select bit
 and foreign-address flag arrive from outside and are synchronised.
*/
// Operation
// - Analog-enable register, address 8, reset c1beff
// - Pump register, address 9, reset 403264
// - Bits 0-4 gate bias, pump, detector, buffers
// - Pad enable low: pin undriven
// - Pad enable and select high: always drive
// - Select low: release on foreign chip address
// - Bits 7,9,10,11 clock, prescaler, bias, amplifier
// - Bits 6:0 down gain, reset 100
// - Bits 13:7 up gain, reset 100
// - Bits 20:14 offset magnitude, reset zero
// - Bit 23 selects high-current pump
`timescale 1ns/100ps
`default_nettype none
`include "aep_defines.vh"

module aep_regs (
    // Clock and reset
    input  wire                      core_clk,
    input  wire                      sys_rst,
    // Register access from serial decoder
    input  wire                      wr_strobe,
    input  wire [`AEP_ADDR_W-1:0]    wr_addr,
    input  wire [`AEP_DATA_W-1:0]    wr_data,
    input  wire [`AEP_ADDR_W-1:0]    rd_addr,
    output reg  [`AEP_DATA_W-1:0]    rd_data,
    // Pin control inputs (outside domain)
    input  wire                      output_select_bit,
    input  wire                      foreign_addr_seen,
    // Shared pin
    output wire                      lock_serial_out_oe_n,
    // Analog enables
    output reg                       bias_on,
    output reg                       pump_on,
    output reg                       phase_detector_on,
    output reg                       ref_buffer_on,
    output reg                       osc_buffer_on,
    output reg                       divided_osc_clock_gate,
    output reg                       prescaler_clock_on,
    output reg                       prescaler_bias_on,
    output reg                       pump_amp_on,
    output reg                       high_freq_ref,
    // Pump settings
    output reg  [6:0]                pump_down_gain,
    output reg  [6:0]                pump_up_gain,
    output reg  [6:0]                pump_offset_mag,
    output reg                       up_offset_enable,
    output reg                       down_offset_enable,
    output reg                       high_current_pump_select
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    reg [1:0] sel_sync;
    reg [1:0] foreign_sync;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_sync     <= 2'h0;
            foreign_sync <= 2'h0;
        end else begin
            sel_sync     <= {sel_sync[0], output_select_bit};
            foreign_sync <= {foreign_sync[0], foreign_addr_seen};
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    wire [`AEP_DATA_W-1:0] analog_enable_ctrl;
    wire [`AEP_DATA_W-1:0] pump_current_ctrl;
    wire                   wr_analog;
    wire                   wr_pump;

    assign wr_analog = wr_strobe && (wr_addr == `AEP_ADDR_ANALOG);
    assign wr_pump   = wr_strobe && (wr_addr == `AEP_ADDR_PUMP);

    aep_reg24 #(
        .RST_VAL (`AEP_RST_ANALOG)
    ) u_analog (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_analog),
        .wr_data  (wr_data),
        .value    (analog_enable_ctrl)
    );

    aep_reg24 #(
        .RST_VAL (`AEP_RST_PUMP)
    ) u_pump (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_pump),
        .wr_data  (wr_data),
        .value    (pump_current_ctrl)
    );

    // ----------------------------------------------------------------
    // Read back
    // ----------------------------------------------------------------
    // Reads only select; nothing changes state on a read
    reg [`AEP_DATA_W-1:0] next_rd_data;

    always @* begin
        case (rd_addr)
            `AEP_ADDR_ANALOG: next_rd_data = analog_enable_ctrl;
            `AEP_ADDR_PUMP:   next_rd_data = pump_current_ctrl;
            default:          next_rd_data = 24'h000000;
        endcase
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 24'h000000;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // ----------------------------------------------------------------
    // Field outputs, registered so every output comes from a flop
    // ----------------------------------------------------------------
    // One cycle behind the register; analog settles far slower anyway
    // Reset copies come from the register reset words so the two cannot drift apart
    localparam [`AEP_DATA_W-1:0] RST_ANALOG = `AEP_RST_ANALOG;
    localparam [`AEP_DATA_W-1:0] RST_PUMP   = `AEP_RST_PUMP;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bias_on                  <= RST_ANALOG[`AEP_BIT_BIAS];
            pump_on                  <= RST_ANALOG[`AEP_BIT_PUMP_ON];
            phase_detector_on        <= RST_ANALOG[`AEP_BIT_PD_ON];
            ref_buffer_on            <= RST_ANALOG[`AEP_BIT_REFBUF];
            osc_buffer_on            <= RST_ANALOG[`AEP_BIT_OSCBUF];
            divided_osc_clock_gate   <= RST_ANALOG[`AEP_BIT_DIVCLK];
            prescaler_clock_on       <= RST_ANALOG[`AEP_BIT_PRESCLK];
            prescaler_bias_on        <= RST_ANALOG[`AEP_BIT_PRESBIAS];
            pump_amp_on              <= RST_ANALOG[`AEP_BIT_AMP];
            high_freq_ref            <= RST_ANALOG[`AEP_BIT_HIREF];
            pump_down_gain           <= RST_PUMP[`AEP_DN_MSB:`AEP_DN_LSB];
            pump_up_gain             <= RST_PUMP[`AEP_UP_MSB:`AEP_UP_LSB];
            pump_offset_mag          <= RST_PUMP[`AEP_OFS_MSB:`AEP_OFS_LSB];
            up_offset_enable         <= RST_PUMP[`AEP_BIT_OFS_UP];
            down_offset_enable       <= RST_PUMP[`AEP_BIT_OFS_DN];
            high_current_pump_select <= RST_PUMP[`AEP_BIT_HICP];
        end else begin
            bias_on                  <= analog_enable_ctrl[`AEP_BIT_BIAS];
            pump_on                  <= analog_enable_ctrl[`AEP_BIT_PUMP_ON];
            phase_detector_on        <= analog_enable_ctrl[`AEP_BIT_PD_ON];
            ref_buffer_on            <= analog_enable_ctrl[`AEP_BIT_REFBUF];
            osc_buffer_on            <= analog_enable_ctrl[`AEP_BIT_OSCBUF];
            divided_osc_clock_gate   <= analog_enable_ctrl[`AEP_BIT_DIVCLK];
            prescaler_clock_on       <= analog_enable_ctrl[`AEP_BIT_PRESCLK];
            prescaler_bias_on        <= analog_enable_ctrl[`AEP_BIT_PRESBIAS];
            pump_amp_on              <= analog_enable_ctrl[`AEP_BIT_AMP];
            high_freq_ref            <= analog_enable_ctrl[`AEP_BIT_HIREF];
            pump_down_gain           <= pump_current_ctrl[`AEP_DN_MSB:`AEP_DN_LSB];
            pump_up_gain             <= pump_current_ctrl[`AEP_UP_MSB:`AEP_UP_LSB];
            pump_offset_mag          <= pump_current_ctrl[`AEP_OFS_MSB:`AEP_OFS_LSB];
            up_offset_enable         <= pump_current_ctrl[`AEP_BIT_OFS_UP];
            down_offset_enable       <= pump_current_ctrl[`AEP_BIT_OFS_DN];
            high_current_pump_select <= pump_current_ctrl[`AEP_BIT_HICP];
        end
    end

    // ----------------------------------------------------------------
    // Shared pin control
    // ----------------------------------------------------------------
    aep_pad_ctrl u_pad (
        .core_clk          (core_clk),
        .sys_rst           (sys_rst),
        .pad_en            (analog_enable_ctrl[`AEP_BIT_PAD_EN]),
        .output_select_bit (sel_sync[1]),
        .foreign_addr      (foreign_sync[1]),
        .pin_oe_n          (lock_serial_out_oe_n)
    );

endmodule // aep_regs
`default_nettype wire

// >>> dv/aep_regs_props.sv
/*
 Checker for the analog-enable and pump-current register pair.
 Assumes it is bound to aep_regs, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module aep_regs_props (
    // Clock, reset and access
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        wr_strobe,
    input wire logic [4:0]  wr_addr,
    input wire logic [23:0] wr_data,
    input wire logic [4:0]  rd_addr,
    input wire logic [23:0] rd_data,
    // Pin control
    input wire logic        output_select_bit,
    input wire logic        foreign_addr_seen,
    input wire logic        lock_serial_out_oe_n,
    // Fields
    input wire logic        bias_on,
    input wire logic        pump_on,
    input wire logic        phase_detector_on,
    input wire logic        ref_buffer_on,
    input wire logic        osc_buffer_on,
    input wire logic        divided_osc_clock_gate,
    input wire logic        prescaler_clock_on,
    input wire logic        prescaler_bias_on,
    input wire logic        pump_amp_on,
    input wire logic        high_freq_ref,
    input wire logic [6:0]  pump_down_gain,
    input wire logic [6:0]  pump_up_gain,
    input wire logic [6:0]  pump_offset_mag,
    input wire logic        up_offset_enable,
    input wire logic        down_offset_enable,
    input wire logic        high_current_pump_select
);
    logic        pad_sh;
    logic [9:0]  an_f;
    logic [9:0]  an_d;
    logic [23:0] pu_f;
    assign an_f = {high_freq_ref, pump_amp_on, prescaler_bias_on, prescaler_clock_on,
                   divided_osc_clock_gate, osc_buffer_on, ref_buffer_on,
                   phase_detector_on, pump_on, bias_on};
    assign an_d = {wr_data[21], wr_data[11:9], wr_data[7], wr_data[4:0]};
    assign pu_f = {high_current_pump_select, down_offset_enable, up_offset_enable,
                   pump_offset_mag, pump_up_gain, pump_down_gain};
    // Shadow of the pad bit, since the pin rules hinge on a bit with no port
    always @(posedge core_clk or posedge sys_rst)
        if (sys_rst) pad_sh <= 1'b1;
        else if (wr_strobe && wr_addr == 5'h08) pad_sh <= wr_data[5];
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_reset_values: assert property ($fell(sys_rst) |->
        an_f == 10'h1ff && pu_f == 24'h403264) else $error("reset field values");
    a_analog_fields: assert property ((wr_strobe && wr_addr == 5'h08) ##1 !wr_strobe [*3]
        |-> an_f == $past(an_d, 3)) else $error("analog fields not written");
    a_pump_fields: assert property ((wr_strobe && wr_addr == 5'h09) ##1 !wr_strobe [*3]
        |-> pu_f == $past(wr_data, 3)) else $error("pump fields not written");
    a_analog_read: assert property ((wr_strobe && wr_addr == 5'h08 && rd_addr == 5'h08)
        ##1 (!wr_strobe && rd_addr == 5'h08) [*3] |-> rd_data == $past(wr_data, 3))
        else $error("read back differs");
    a_unmapped_zero: assert property ((rd_addr != 5'h08 && rd_addr != 5'h09) |=>
        rd_data == 24'h000000) else $error("unmapped read not zero");
    a_pad_off: assert property (!pad_sh [*3] |-> lock_serial_out_oe_n)
        else $error("pin driven with pad off");
    a_gpo_drive: assert property ((pad_sh && output_select_bit) [*4] |->
        !lock_serial_out_oe_n) else $error("pin not driven for output use");
    a_foreign_release: assert property ((pad_sh && !output_select_bit && foreign_addr_seen) [*4]
        |-> lock_serial_out_oe_n) else $error("pin driven on foreign address");
    a_own_drive: assert property ((pad_sh && !output_select_bit && !foreign_addr_seen) [*4]
        |-> !lock_serial_out_oe_n) else $error("pin released on own address");
endmodule // aep_regs_props
bind aep_regs aep_regs_props i_props (.*);
`default_nettype wire

// >>> dv/aep_host.sv
/*
 Serial host stand-in: writes and reads the register pair and drives the
 pin-control lines. Assumes the bench calls its tasks; drives on falling edges.
*/
`timescale 1ns/100ps
`default_nettype none
module aep_host (
    // Clock and read data
    input  wire logic        core_clk,
    input  wire logic [23:0] rd_data,
    // Register access
    output var logic         wr_strobe,
    output var logic [4:0]   wr_addr,
    output var logic [23:0]  wr_data,
    output var logic [4:0]   rd_addr,
    // Pin control
    output var logic         output_select_bit,
    output var logic         foreign_addr_seen
);
    initial begin
        wr_strobe = 1'b0;
        wr_addr = 5'h1f;
        wr_data = 24'h000000;
        rd_addr = 5'h08;
        output_select_bit = 1'b0;
        foreign_addr_seen = 1'b0;
    end
    // Lines are scrambled after a write so stale data cannot pass for a hold
    task write_reg(input logic [4:0] a, input logic [23:0] d);
        @(negedge core_clk);
        wr_strobe = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge core_clk);
        wr_strobe = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
        repeat (3) @(negedge core_clk);
    endtask
    task read_reg(input logic [4:0] a, output logic [23:0] d);
        @(negedge core_clk);
        rd_addr = a;
        repeat (2) @(negedge core_clk);
        d = rd_data;
    endtask
    // Synchroniser plus pin flop need three edges; five leaves margin
    task set_pins(input logic s, input logic f);
        @(negedge core_clk);
        output_select_bit = s;
        foreign_addr_seen = f;
        repeat (5) @(negedge core_clk);
    endtask
endmodule // aep_host
`default_nettype wire

// >>> dv/analog_enable_pump_regs_tb_top.sv
/*
 Self-checking bench for the register pair and its pin control.
 Assumes aep_regs, aep_host and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define AEP_CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, (got), (exp)); end end
module analog_enable_pump_regs_tb_top;
    localparam logic [23:0] A = 24'h6abeff;
    localparam logic [23:0] P = 24'hd5a5c3;
    localparam logic [23:0] P2 = 24'h4aaa55;
    logic core_clk, sys_rst;
    wire wr_strobe, output_select_bit, foreign_addr_seen, lock_serial_out_oe_n;
    wire [4:0] wr_addr, rd_addr;
    wire [23:0] wr_data, rd_data;
    wire bias_on, pump_on, phase_detector_on, ref_buffer_on, osc_buffer_on;
    wire divided_osc_clock_gate, prescaler_clock_on, prescaler_bias_on, pump_amp_on;
    wire high_freq_ref, up_offset_enable, down_offset_enable, high_current_pump_select;
    wire [6:0] pump_down_gain, pump_up_gain, pump_offset_mag;
    wire [9:0] an_f = {high_freq_ref, pump_amp_on, prescaler_bias_on, prescaler_clock_on,
        divided_osc_clock_gate, osc_buffer_on, ref_buffer_on, phase_detector_on, pump_on, bias_on};
    wire [23:0] pu_f = {high_current_pump_select, down_offset_enable, up_offset_enable,
        pump_offset_mag, pump_up_gain, pump_down_gain};
    int err_count, check_count;
    logic [23:0] rd;
    aep_regs i_dut (.*);
    aep_host i_host (.*);
    always #12.5 core_clk = ~core_clk;
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset_state;
        i_host.read_reg(5'h09, rd);
        `AEP_CHK(rd, 24'h403264);
        i_host.read_reg(5'h08, rd);
        `AEP_CHK(rd, 24'hc1beff);
        `AEP_CHK(an_f, 10'h1ff);
        `AEP_CHK(pu_f[6:0], 7'h64);
        `AEP_CHK(pu_f[13:7], 7'h64);
        `AEP_CHK(pu_f[20:14], 7'h00);
        `AEP_CHK(pu_f[23], 1'b0);
        `AEP_CHK(pu_f[22:21], 2'h2);
        `AEP_CHK(lock_serial_out_oe_n, 1'b0);
    endtask
    // Reserved bits 16, 17, 19 and 23 differ from reset so a partial store shows up
    task t_write_read;
        i_host.write_reg(5'h08, A); // Bit 21 set for a fast reference
        i_host.write_reg(5'h09, P); // Offset enables kept as advised
        `AEP_CHK(an_f, {A[21], A[11:9], A[7], A[4:0]});
        `AEP_CHK(pu_f, P);
        i_host.write_reg(5'h09, P2);
        i_host.write_reg(5'h0a, 24'hffffff);
        i_host.read_reg(5'h08, rd);
        `AEP_CHK(rd, A);
        i_host.read_reg(5'h09, rd);
        `AEP_CHK(rd, P2);
        i_host.read_reg(5'h0a, rd);
        `AEP_CHK(rd, 24'h000000);
    endtask
    task t_pin;
        int p, j;
        logic e;
        for (p = 0; p < 2; p++) begin
            i_host.write_reg(5'h08, {A[23:6], p[0], A[4:0]});
            for (j = 0; j < 4; j++) begin
                i_host.set_pins(j[1], j[0]);
                e = (p == 0) ? 1'b1 : (j[1] ? 1'b0 : j[0]);
                `AEP_CHK(lock_serial_out_oe_n, e);
            end
        end
    endtask
    task t_mid_reset;
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        i_host.read_reg(5'h08, rd);
        `AEP_CHK(rd, 24'hc1beff);
        i_host.read_reg(5'h09, rd);
        `AEP_CHK(rd, 24'h403264);
        `AEP_CHK(an_f, 10'h1ff);
        `AEP_CHK(pu_f, 24'h403264);
        `AEP_CHK(lock_serial_out_oe_n, 1'b0);
    endtask
    task end_sim;
        if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        err_count = 0;
        check_count = 0;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        t_reset_state;
        t_write_read;
        t_pin;
        t_mid_reset;
        end_sim;
    end
endmodule // analog_enable_pump_regs_tb_top
`default_nettype wire
